//--- txp_pkg.sv
// constants shared by the transmit buffer command parser
// assumes a 32-bit word stream from the host side data fifo
// How it works
// R1 - bit 13 first, bit 12 last segment
// R2 - buffer size in command A bits 10:0
// R3 - packet length excludes offset and filler
// R4 - summed sizes differing from length set error
// R5 - tag passes unchanged into the status
// R6 - checksum needs request, first flag, engine enable
// R7 - command B bit 13 drops the crc
// R8 - command B bit 12 stops short-frame padding
// R9 - padding disabled still appends the crc
// R10 - host writes zero to reserved bits
// R11 - data section starts at first word after command B, at second word in later segments
// R12 - offset low bits pick first byte lane
// R13 - offset upper bits skip up to seven words
// R14 - trailing unused bytes never forwarded
// R15 - host pads buffer to chosen alignment
// R16 - end alignment filler is discarded
// R17 - data start offset sits in bits 20:16
// R18 - middle buffers hold at least four bytes
// R19 - command B only follows a first segment
// R20 - command words never reach the frame data
package txp_pkg;
   // command A fields
   localparam int A_FIRST = 13;
   localparam int A_LAST = 12;
   localparam int SIZE_W = 11;
   localparam int A_OFF_LO = 16;
   localparam int A_OFF_HI = 20;
   localparam int A_AL_LO = 24;
   localparam int A_AL_HI = 25;
   // command B fields
   localparam int B_TAG_LO = 16;
   localparam int B_CK = 14;
   localparam int B_NOCRC = 13;
   localparam int B_NOPAD = 12;
   // end alignment codes and word masks
   localparam logic [1:0] AL_16 = 2'h1;
   localparam logic [1:0] AL_32 = 2'h2;
   localparam logic [10:0] MASK_16 = 11'h003;
   localparam logic [10:0] MASK_32 = 11'h007;
   // register offsets and bit positions
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_STAT = 4'h4;
   localparam logic [3:0] ADR_TAG = 4'h8;
   localparam int BIT_ENG = 0;
   localparam int BIT_ERR = 0;
   localparam int BIT_OPEN = 1;
   // parser states
   typedef enum logic [1:0] {
      S_CMDA = 2'b00,
      S_CMDB = 2'b01,
      S_DATA = 2'b10
   } txp_state_t;
endpackage

//--- txp_parser.sv
// transmit buffer command parser: words in, payload bytes out
// assumes a word source with valid/ready, a byte sink with valid/ready
// and a classic wishbone master for the control registers
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module txp_parser
   import txp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // buffer word stream from host
   input wire logic in_valid,
   input wire logic [31:0] in_data,
   output logic in_ready,
   // payload bytes toward mac side transmit fifo
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_last,
   input wire logic out_ready,
   // per-frame controls, valid from command B onward
   output logic csum_do,
   output logic crc_add,
   output logic pad_add,
   // per-packet status
   output logic stat_valid,
   output logic [15:0] stat_tag,
   output logic stat_err
);

   ////////////////////////////////////////////////////////////////////
   // state
   txp_state_t state_reg, state_next;
   logic [SIZE_W-1:0] size_reg; // size of current buffer
   logic [SIZE_W:0] sum_reg; // running packet byte sum
   logic [SIZE_W-1:0] len_reg; // packet length from command B
   logic [1:0] off_lo_reg; // first byte lane
   logic [2:0] skip_reg; // leading words to drop
   logic [10:0] dend_reg; // index after last data word
   logic [10:0] total_reg; // aligned word count of section
   logic [10:0] idx_reg; // data section word index
   logic last_reg; // buffer closes the packet
   logic first_reg; // buffer opens the packet
   logic open_reg; // a packet is in progress
   logic [31:0] word_reg; // word being serialised
   logic [1:0] lane_reg; // current byte lane
   logic [SIZE_W-1:0] left_reg; // payload bytes still due
   logic busy_reg; // serialiser holds bytes
   logic [15:0] tag_reg;
   logic csum_reg, crc_reg, pad_reg, stat_v_reg, stat_e_reg;
   logic eng_en_reg, err_flag_reg, ack_reg;
   logic [31:0] rdat_reg;

   ////////////////////////////////////////////////////////////////////
   // word count of the data section, rounded up to the end alignment
   function automatic logic [10:0] align_words(input logic [10:0] w, input logic [1:0] al);
      logic [10:0] m;
      m = (al == AL_16) ? MASK_16 : (al == AL_32) ? MASK_32 : 11'h000;
      align_words = (w + m) & ~m;
   endfunction

   // command A decode straight off the input word
   wire [SIZE_W-1:0] a_size = in_data[SIZE_W-1:0]; // R2
   wire [4:0] a_off = in_data[A_OFF_HI:A_OFF_LO]; // R17
   wire [1:0] a_al = in_data[A_AL_HI:A_AL_LO];
   wire a_first = in_data[A_FIRST]; // R1
   wire a_last = in_data[A_LAST]; // R1
   wire [11:0] a_span = {10'h000, a_off[1:0]} + {1'b0, a_size} + 12'h003;
   wire [10:0] a_dend = {8'h00, a_off[4:2]} + {1'b0, a_span[11:2]}; // R13
   wire [10:0] a_total = align_words(a_dend, a_al); // R15 R16

   // handshakes
   wire take = in_valid && in_ready;
   wire take_a = take && state_reg == S_CMDA;
   wire take_b = take && state_reg == S_CMDB;
   wire take_d = take && state_reg == S_DATA;
   wire in_range = idx_reg >= {8'h00, skip_reg} && idx_reg < dend_reg;
   wire buf_end = state_reg == S_DATA && !busy_reg && idx_reg == total_reg;
   wire pop = out_valid && out_ready;
   wire mismatch = sum_reg != {1'b0, len_reg}; // R4

   // the parser stalls its source while a word is being serialised
   assign in_ready = (state_reg != S_DATA) || (!busy_reg && idx_reg != total_reg);
   assign out_valid = busy_reg; // R20
   assign out_data = word_reg[{lane_reg, 3'b000} +: 8]; // R12
   assign out_last = busy_reg && last_reg && left_reg == 11'h001;

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         S_CMDA: if (take_a) state_next = a_first ? S_CMDB : S_DATA; // R19
         S_CMDB: if (take_b) state_next = S_DATA; // R11
         S_DATA: if (buf_end) state_next = S_CMDA;
         default: state_next = S_CMDA;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst) state_reg <= S_CMDA;
      else state_reg <= state_next;
   end

   ////////////////////////////////////////////////////////////////////
   // buffer geometry, captured from command A
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         size_reg <= '0; off_lo_reg <= '0; skip_reg <= '0;
         dend_reg <= '0; total_reg <= '0; last_reg <= 1'b0; first_reg <= 1'b0;
      end
      else if (take_a)
      begin
         size_reg <= a_size;
         off_lo_reg <= a_off[1:0];
         skip_reg <= a_off[4:2];
         dend_reg <= a_dend;
         total_reg <= a_total;
         last_reg <= a_last;
         first_reg <= a_first;
      end
   end

   // running byte sum; a first segment restarts it
   always_ff @(posedge clk)
   begin
      if (!nrst) sum_reg <= '0;
      else if (take_a) sum_reg <= (a_first ? '0 : sum_reg) + {1'b0, a_size}; // R4
   end

   // packet open flag, shown in status
   always_ff @(posedge clk)
   begin
      if (!nrst) open_reg <= 1'b0;
      else if (take_a && a_first) open_reg <= 1'b1;
      else if (buf_end && last_reg) open_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // command B: tag, length and frame controls
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         tag_reg <= '0; len_reg <= '0;
         csum_reg <= 1'b0; crc_reg <= 1'b1; pad_reg <= 1'b1;
      end
      else if (take_b)
      begin
         tag_reg <= in_data[31:B_TAG_LO]; // R5
         len_reg <= in_data[SIZE_W-1:0]; // R3
         csum_reg <= in_data[B_CK] && first_reg && eng_en_reg; // R6
         crc_reg <= !in_data[B_NOCRC] || in_data[B_NOPAD]; // R7 R9
         pad_reg <= !in_data[B_NOPAD]; // R8
      end
   end
   assign csum_do = csum_reg;
   assign crc_add = crc_reg;
   assign pad_add = pad_reg;

   ////////////////////////////////////////////////////////////////////
   // data section word index; skip and filler words are swallowed
   always_ff @(posedge clk)
   begin
      if (!nrst) idx_reg <= '0;
      else if (take_a) idx_reg <= '0; // R11
      else if (take_d) idx_reg <= idx_reg + 11'h001; // R13 R16
   end

   // serialiser: only in-range words load, so commands never leak
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         word_reg <= '0; lane_reg <= '0; busy_reg <= 1'b0; left_reg <= '0;
      end
      else if (take_a) left_reg <= a_size;
      else if (take_d && in_range)
      begin
         word_reg <= in_data;
         lane_reg <= (idx_reg == {8'h00, skip_reg}) ? off_lo_reg : 2'h0; // R12
         busy_reg <= left_reg != '0; // R14
      end
      else if (pop)
      begin
         left_reg <= left_reg - 11'h001;
         lane_reg <= lane_reg + 2'h1;
         if (lane_reg == 2'h3 || left_reg == 11'h001) busy_reg <= 1'b0; // R14
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status pulse at the end of the last segment
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         stat_v_reg <= 1'b0; stat_e_reg <= 1'b0;
      end
      else
      begin
         stat_v_reg <= buf_end && last_reg; // R1
         if (buf_end && last_reg) stat_e_reg <= mismatch; // R4
      end
   end
   assign stat_valid = stat_v_reg;
   assign stat_tag = tag_reg; // R5
   assign stat_err = stat_e_reg;

   ////////////////////////////////////////////////////////////////////
   // wishbone slave: one wait state, unmapped reads zero
   wire wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
   wire wr = wb_req && wb_we_i && wb_sel_i[0];
   wire sel_ctrl = wb_adr_i == ADR_CTRL;
   wire sel_stat = wb_adr_i == ADR_STAT;
   wire sel_tag = wb_adr_i == ADR_TAG;
   wire err_set = buf_end && last_reg && mismatch;
   wire err_clr = wr && sel_stat && wb_dat_i[BIT_ERR];
   wire [31:0] rd_mux =
      sel_ctrl ? {31'h0, eng_en_reg} :
      sel_stat ? {30'h0, open_reg, err_flag_reg} :
      sel_tag ? {16'h0000, tag_reg} : 32'h00000000;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ack_reg <= 1'b0; rdat_reg <= '0; eng_en_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= wb_req;
         rdat_reg <= wb_req ? rd_mux : 32'h00000000;
         if (wr && sel_ctrl) eng_en_reg <= wb_dat_i[BIT_ENG];
      end
   end

   // sticky error: a set in the clearing cycle wins
   always_ff @(posedge clk)
   begin
      if (!nrst) err_flag_reg <= 1'b0;
      else if (err_set) err_flag_reg <= 1'b1; // R4
      else if (err_clr) err_flag_reg <= 1'b0;
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_no_cmd_out;
      out_valid |-> state_reg == S_DATA;
   endproperty
   a_no_cmd_out: assert property (p_no_cmd_out) else $error("byte out of data"); // R20
   property p_csum;
      take_b |=> csum_do == ($past(in_data[B_CK]) && first_reg && $past(eng_en_reg));
   endproperty
   a_csum: assert property (p_csum) else $error("checksum gating wrong"); // R6
   property p_crc;
      take_b |=> crc_add == !($past(in_data[B_NOCRC]) && !$past(in_data[B_NOPAD]));
   endproperty
   a_crc: assert property (p_crc) else $error("crc control wrong"); // R7
   property p_pad;
      take_b && in_data[B_NOPAD] |=> !pad_add && crc_add;
   endproperty
   a_pad: assert property (p_pad) else $error("pad disable wrong"); // R9
   property p_tag;
      take_b |=> stat_tag == $past(in_data[31:B_TAG_LO]);
   endproperty
   a_tag: assert property (p_tag) else $error("tag not kept"); // R5
   property p_err;
      stat_valid && stat_err |-> err_flag_reg;
   endproperty
   a_err: assert property (p_err) else $error("error flag not set"); // R4
   property p_lane;
      take_d && idx_reg == {8'h00, skip_reg} && left_reg != '0 |=> lane_reg == off_lo_reg;
   endproperty
   a_lane: assert property (p_lane) else $error("first lane wrong"); // R12
   property p_skip;
      take_d && !in_range |=> !busy_reg;
   endproperty
   a_skip: assert property (p_skip) else $error("skip or filler sent"); // R16
   property p_tail;
      pop && left_reg == 11'h001 |=> !out_valid;
   endproperty
   a_tail: assert property (p_tail) else $error("trailing byte sent"); // R14
   property p_stat;
      stat_valid |-> $past(last_reg) && state_reg == S_CMDA;
   endproperty
   a_stat: assert property (p_stat) else $error("status without last"); // R1

   c_err: cover property (stat_valid && stat_err);
   c_last: cover property (pop && out_last);
   c_skip: cover property (take_d && skip_reg != 3'h0 && idx_reg == 11'h000);
   c_fill: cover property (take_d && idx_reg >= dend_reg);
endmodule

//--- txp_host_model.sv
// host side model: builds transmit buffers and streams them as words
// assumes the parser word port: a word stands until ready is seen high
`timescale 1ns/1ns
module txp_host_model
   import txp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // word stream toward the parser
   output logic in_valid,
   output logic [31:0] in_data,
   input wire logic in_ready,
   // pacing: idle cycles between words when high
   input wire logic slow
);
   logic [31:0] q[$]; // words waiting to go out
   logic gap_reg; // alternating gap when slow
   ////////////////////////////////////////////////////////////////////
   // one buffer: command words, skipped words, payload, filler
   task automatic send_buf(input logic fs, input logic ls, input logic [10:0] size,
      input logic [4:0] off, input logic [1:0] al, input logic [31:0] cmdb,
      input logic [7:0] base);
      int nw;
      int p;
      logic [31:0] w;
      nw = (off + size + 3) / 4;
      nw = (al == 2'h1) ? (nw + 3) / 4 * 4 : (al == 2'h2) ? (nw + 7) / 8 * 8 : nw;
      q.push_back({6'h00, al, 3'h0, off, 2'h0, fs, ls, 1'b0, size});
      if (fs)
      begin
         q.push_back(cmdb);
      end
      for (int i = 0; i < nw; i++)
      begin
         for (int k = 0; k < 4; k++)
         begin
            p = i * 4 + k - off;
            w[k*8+:8] = (p >= 0 && p < size) ? base + p[7:0] : 8'hEE;
         end
         q.push_back(w);
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   // word driver; a released bus shows the inverse, not the last word
   always @(posedge clk)
   begin
      if (!nrst)
      begin
         in_valid <= 1'b0;
         in_data <= 32'h00000000;
         gap_reg <= 1'b0;
      end
      else if (!in_valid || in_ready)
      begin
         gap_reg <= ~gap_reg;
         if (q.size() != 0 && !(slow && gap_reg))
         begin
            in_valid <= 1'b1;
            in_data <= q.pop_front();
         end
         else
         begin
            in_valid <= 1'b0;
            in_data <= ~in_data;
         end
      end
   end
endmodule

//--- txp_parser_tb.sv
// self-checking bench for the transmit buffer command parser
// assumes the host model beside it and a wishbone master in tasks
`timescale 1ns/1ns
module txp_parser_tb
   import txp_pkg::*;
;
   logic clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack, in_valid, in_ready;
   logic [3:0] wb_adr, wb_sel;
   logic [31:0] wb_dat, wb_rd, in_data, r;
   logic out_valid, out_last, out_ready, slow, csum_do, crc_add, pad_add;
   logic stat_valid, stat_err;
   logic [7:0] out_data;
   logic [15:0] stat_tag;
   logic [8:0] got[$], exp[$]; // {last, byte}
   logic [16:0] sq[$]; // {err, tag}
   int err_total, check_count;
   ////////////////////////////////////////////////////////////////////
   txp_parser txp_parser_inst (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .in_valid(in_valid),
      .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
      .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
      .csum_do(csum_do), .crc_add(crc_add), .pad_add(pad_add),
      .stat_valid(stat_valid), .stat_tag(stat_tag), .stat_err(stat_err));
   txp_host_model txp_host_model_inst (.clk(clk), .nrst(nrst), .in_valid(in_valid),
      .in_data(in_data), .in_ready(in_ready), .slow(slow));
   ////////////////////////////////////////////////////////////////////
   // clock, stalling sink and output monitors
   always #20 clk = ~clk;
   always @(posedge clk)
   begin
      out_ready <= slow ? ~out_ready : 1'b1;
      if (nrst && out_valid === 1'b1 && out_ready)
         got.push_back({out_last, out_data});
      if (nrst && stat_valid === 1'b1)
         sq.push_back({stat_err, stat_tag});
   end
   ////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // classic single cycle; held until ack is sampled high
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {1'b1, 1'b1, we, a, d};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         err_total++;
         results();
      end
      r = wb_rd;
      {wb_cyc, wb_stb, wb_we} <= 3'h0;
   endtask
   task automatic add_exp(input logic [7:0] base, input int n);
      for (int i = 0; i < n; i++)
         exp.push_back({i == n - 1, base + i[7:0]});
   endtask
   // waits for one status, then compares status and payload bytes
   task automatic run_pkt(input logic e, input logic [15:0] tag);
      int n;
      logic [16:0] s;
      n = 0;
      while (sq.size() == 0 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      if (sq.size() == 0)
      begin
         err_total++;
         results();
      end
      s = sq.pop_front();
      check(s[16], e);
      check(s[15:0], tag);
      check(got.size(), exp.size());
      foreach (exp[i]) check(got[i], exp[i]);
      got.delete();
      exp.delete();
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      {clk, nrst, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, slow} = 0;
      wb_sel = 4'hF;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      wb(0, ADR_CTRL, 0);
      check(r, 0);
      wb(1, ADR_CTRL, 1);
      wb(0, ADR_CTRL, 0);
      check(r, 1);
      wb(1, 4'hC, 32'hFFFFFFFF);
      wb(0, 4'hC, 0);
      check(r, 0);
      // an unmapped write must leave the engine enable alone
      wb(0, ADR_CTRL, 0);
      check(r, 1);
      $display("test registers done");
      for (int i = 0; i < 4; i++)
      begin
         txp_host_model_inst.send_buf(1, 1, 2, 0, 0,
            {12'hA00, i[3:0], 2'b01, i[1], i[0], 12'h002}, 8'h10);
         add_exp(8'h10, 2);
         run_pkt(0, {12'hA00, i[3:0]});
         check(csum_do, 1);
         check(crc_add, !i[1] || i[0]);
         check(pad_add, !i[0]);
      end
      wb(0, ADR_TAG, 0);
      check(r, 32'h0000A003);
      $display("test command flags done");
      slow <= 1'b1;
      txp_host_model_inst.send_buf(1, 1, 5, 5'h0B, 1, 32'hB0B00005, 8'h40);
      add_exp(8'h40, 5);
      run_pkt(0, 16'hB0B0);
      check(csum_do, 0);
      $display("test offset and alignment done");
      slow <= 1'b0;
      wb(1, ADR_CTRL, 0);
      // first, middle and last segment; sizes sum to 11 against a length of 9
      txp_host_model_inst.send_buf(1, 0, 3, 5'h01, 2, 32'hC0C04009, 8'h30);
      txp_host_model_inst.send_buf(0, 0, 4, 0, 0, 0, 8'h33);
      txp_host_model_inst.send_buf(0, 1, 4, 0, 0, 0, 8'h37);
      add_exp(8'h30, 11);
      run_pkt(1, 16'hC0C0);
      check(csum_do, 0);
      wb(0, ADR_STAT, 0);
      check(r, 1);
      wb(1, ADR_STAT, 1);
      wb(0, ADR_STAT, 0);
      check(r, 0);
      $display("test segments and length error done");
      results();
   end
endmodule
